// ===== hdl/cxbs_bootstrap_regs.sv
// Bootstrap, link control and self-check register set
// What this block does
// R1: Link speed picks one connection at low, mid or high rate, three codes.
// R2: Host stops acquisition before changing link speed.
// R3: Writing one to link reset control resets all connections.
// R4: Max stream packet bytes resets to zero, host-written, multiple of four.
// R5: Max control packet bytes is read-only and a multiple of four.
// R6: Link test enable sends test packets instead of normal traffic.
// R7: Host writes only a valid connection id into the counter selector.
// R8: Error, tx and rx test totals shown for the selected connection.
// R9: Reading arriving link id returns the connection the read came over.
// R10: Host-written master host link id is stored.
// R11: Read-only default link setting holds a valid speed and count.
// R12: Manifest select picks the entry for version, scheme, pointer; count shown.
// R13: Read-only pointers give addresses of eight image control features.
// R14: Self-check word reports each failure in its own bit.
// R15: Boot, storage, configuration and name checks evaluated once at start-up.
// R16: Stored block corruption sets its weight when read from storage.
// R17: Alignment failure watched continuously, status refreshed every second.
// R18: User label is up to 16 characters, volatile until saved.
// R19: Temperature readout returns the main logic device temperature.
// R20: Save command copies the user label to non-volatile storage.
// R21: Link reset control clears itself when the reset completes.
// R22: Start-up and storage bits stay set; alignment bit follows refresh.
`timescale 1ns/1ns
`default_nettype none
module cxbs_bootstrap_regs
  import cxbs_pkg::*;
#(
  parameter int ALIGN_TICK_CYCLES = ALIGN_CYCLES
)
(
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 speed_wr,
  input  wire logic [1:0]           speed_wdata,
  input  wire logic                 link_reset_wr,
  input  wire logic                 link_reset_wdata,
  input  wire logic                 link_reset_done,
  input  wire logic                 stream_size_wr,
  input  wire logic [31:0]          stream_size_wdata,
  input  wire logic                 test_enable_wr,
  input  wire logic                 test_enable_wdata,
  input  wire logic                 counter_select_wr,
  input  wire logic [ID_W-1:0]      counter_select_wdata,
  input  wire logic                 test_tx_evt,
  input  wire logic                 test_rx_evt,
  input  wire logic                 test_err_evt,
  input  wire logic [ID_W-1:0]      test_evt_link,
  input  wire logic                 link_id_rd,
  input  wire logic [ID_W-1:0]      link_id_rd_link,
  input  wire logic                 master_host_wr,
  input  wire logic [31:0]          master_host_wdata,
  input  wire logic                 manifest_select_wr,
  input  wire logic [MAN_W-1:0]     manifest_select_wdata,
  input  wire logic                 boot_ok,
  input  wire logic                 flash_found,
  input  wire logic                 config_bad,
  input  wire logic                 names_bad,
  input  wire logic                 store_bad,
  input  wire logic [2:0]           store_block,
  input  wire logic                 align_fail,
  input  wire logic [TEMP_W-1:0]    temp_sample,
  input  wire logic                 label_wr,
  input  wire logic [LIDX_W-1:0]    label_index,
  input  wire logic [CHAR_W-1:0]    label_wchar,
  input  wire logic                 save_label_cmd,
  output logic [1:0]                link_speed_select_q,
  output logic                      link_reset_ctrl_q,
  output logic                      link_reset_out_q,
  output logic [31:0]               max_stream_pkt_bytes_q,
  output logic [31:0]               max_ctrl_pkt_bytes_q,
  output logic [31:0]               default_link_setting_q,
  output logic                      link_test_enable_q,
  output logic [ID_W-1:0]           test_counter_select_q,
  output logic [CNT_W-1:0]          test_error_total,
  output logic [CNT_W-1:0]          test_tx_pkt_total,
  output logic [CNT_W-1:0]          test_rx_pkt_total,
  output logic [ID_W-1:0]           arriving_link_id_q,
  output logic [31:0]               master_host_link_id_q,
  output logic [MAN_W-1:0]          manifest_select_q,
  output logic [31:0]               manifest_count_q,
  output logic [31:0]               manifest_version_q,
  output logic [31:0]               manifest_scheme_q,
  output logic [31:0]               manifest_url_q,
  output logic [31:0]               feature_ptr_q [PTR_COUNT],
  output logic [31:0]               self_check_word_q,
  output logic [TEMP_W-1:0]         logic_temp_readout_q,
  output logic [CHAR_W-1:0]         label_rchar_q,
  output logic                      nvm_wr_q,
  output logic [LIDX_W-1:0]         nvm_index_q,
  output logic [CHAR_W-1:0]         nvm_char_q,
  output logic                      save_busy_q
);
  typedef enum {CXBS_RST_IDLE, CXBS_RST_BUSY} cxbs_rst_t;
  typedef enum {CXBS_SAVE_IDLE, CXBS_SAVE_RUN} cxbs_save_t;

  cxbs_rst_t          rst_state_q;
  cxbs_save_t         save_state_q;
  logic [CHAR_W-1:0]  label_q [LABEL_LEN];
  logic               startup_done_q;
  logic [31:0]        align_cnt_q;
  logic               align_tick;
  logic               test_en_prev_q;

  function automatic logic speed_legal(input logic [1:0] v);
    return v == ONE_LINK_LOW_RATE || v == ONE_LINK_MID_RATE || v == ONE_LINK_HIGH_RATE;
  endfunction

  // ************************************
  // Link speed, host-written settings and read-only values
  // ************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
      link_speed_select_q <= SPEED_RESET;
    else if (speed_wr && speed_legal(speed_wdata))   // R1
      link_speed_select_q <= speed_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      max_stream_pkt_bytes_q <= STREAM_PKT_RESET;
    else if (stream_size_wr && stream_size_wdata[1:0] == 2'h0)   // R4
      max_stream_pkt_bytes_q <= stream_size_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      master_host_link_id_q <= '0;
    else if (master_host_wr)   // R10
      master_host_link_id_q <= master_host_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      max_ctrl_pkt_bytes_q   <= '0;
      default_link_setting_q <= '0;
      logic_temp_readout_q   <= '0;
    end
    else
    begin
      max_ctrl_pkt_bytes_q   <= MAX_CTRL_PKT_BYTES;     // R5
      default_link_setting_q <= DEFAULT_LINK_SETTING;   // R11
      logic_temp_readout_q   <= temp_sample;            // R19
    end
  end

  // ************************************
  // Connection reset
  // ************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rst_state_q       <= CXBS_RST_IDLE;
      link_reset_ctrl_q <= 1'b0;
      link_reset_out_q  <= 1'b0;
    end
    else
    begin
      case (rst_state_q)
        CXBS_RST_IDLE:
          if (link_reset_wr && link_reset_wdata)   // R3
          begin
            rst_state_q       <= CXBS_RST_BUSY;
            link_reset_ctrl_q <= 1'b1;
            link_reset_out_q  <= 1'b1;
          end
        CXBS_RST_BUSY:
          if (link_reset_done)   // R21
          begin
            rst_state_q       <= CXBS_RST_IDLE;
            link_reset_ctrl_q <= 1'b0;
            link_reset_out_q  <= 1'b0;
          end
        default:
          rst_state_q <= CXBS_RST_IDLE;
      endcase
    end
  end

  // ************************************
  // Link test mode and counters
  // ************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      link_test_enable_q <= 1'b0;
      test_en_prev_q     <= 1'b0;
    end
    else
    begin
      test_en_prev_q <= link_test_enable_q;
      if (test_enable_wr)   // R6
        link_test_enable_q <= test_enable_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      test_counter_select_q <= '0;
    else if (counter_select_wr)   // R7
      test_counter_select_q <= counter_select_wdata;
  end

  cxbs_cnt_if cnt ();

  // Counters restart on entering test mode or on a connection reset
  assign cnt.enable   = link_test_enable_q;
  assign cnt.clear    = link_reset_out_q || (link_test_enable_q && !test_en_prev_q);
  assign cnt.sel      = test_counter_select_q;   // R8
  assign cnt.evt_link = test_evt_link;
  assign cnt.tx_evt   = test_tx_evt;
  assign cnt.rx_evt   = test_rx_evt;
  assign cnt.err_evt  = test_err_evt;
  assign test_tx_pkt_total = cnt.tx_total;
  assign test_rx_pkt_total = cnt.rx_total;
  assign test_error_total  = cnt.err_total;

  cxbs_test_counters u_counters (
    .mclk  (mclk),
    .reset (reset),
    .ci    (cnt.counter)
  );

  always_ff @(posedge mclk)
  begin
    if (reset)
      arriving_link_id_q <= '0;
    else if (link_id_rd)   // R9
      arriving_link_id_q <= link_id_rd_link;
  end

  // ************************************
  // Manifest and feature pointers
  // ************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
      manifest_select_q <= '0;
    else if (manifest_select_wr)
      manifest_select_q <= manifest_select_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      manifest_count_q   <= '0;
      manifest_version_q <= '0;
      manifest_scheme_q  <= '0;
      manifest_url_q     <= '0;
      for (int i = 0; i < PTR_COUNT; i++)
        feature_ptr_q[i] <= '0;
    end
    else
    begin
      manifest_count_q   <= 32'(MAN_COUNT);                  // R12
      manifest_version_q <= MAN_VERSION[manifest_select_q];
      manifest_scheme_q  <= MAN_SCHEME[manifest_select_q];
      manifest_url_q     <= MAN_URL[manifest_select_q];
      for (int i = 0; i < PTR_COUNT; i++)
        feature_ptr_q[i] <= FEAT_PTR[i];                     // R13
    end
  end

  // ************************************
  // Self-check word
  // ************************************
  assign align_tick = align_cnt_q == 32'(ALIGN_TICK_CYCLES - 1);

  always_ff @(posedge mclk)
  begin
    if (reset || align_tick)
      align_cnt_q <= '0;
    else
      align_cnt_q <= align_cnt_q + 32'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      self_check_word_q <= '0;
      startup_done_q    <= 1'b0;
    end
    else
    begin
      if (!startup_done_q)   // R15
      begin
        startup_done_q               <= 1'b1;
        self_check_word_q[BIT_BOOT]  <= !boot_ok;
        self_check_word_q[BIT_FLASH] <= !flash_found;
        self_check_word_q[BIT_CFG]   <= config_bad;
        self_check_word_q[BIT_NAMES] <= names_bad;
      end
      if (store_bad)   // R16 R14 R22
        self_check_word_q[STORE_BIT[store_block]] <= 1'b1;
      if (align_tick)   // R17
        self_check_word_q[BIT_ALIGN] <= align_fail;
    end
  end

  // ************************************
  // User label and save
  // ************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < LABEL_LEN; i++)
        label_q[i] <= '0;
    end
    else if (label_wr)   // R18
      label_q[label_index] <= label_wchar;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      label_rchar_q <= '0;
    else
      label_rchar_q <= label_q[label_index];
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      save_state_q <= CXBS_SAVE_IDLE;
      nvm_wr_q     <= 1'b0;
      nvm_index_q  <= '0;
      nvm_char_q   <= '0;
      save_busy_q  <= 1'b0;
    end
    else
    begin
      case (save_state_q)
        CXBS_SAVE_IDLE:
          if (save_label_cmd)   // R20
          begin
            save_state_q <= CXBS_SAVE_RUN;
            save_busy_q  <= 1'b1;
            nvm_wr_q     <= 1'b1;
            nvm_index_q  <= '0;
            nvm_char_q   <= label_q[0];
          end
        CXBS_SAVE_RUN:
          if (nvm_index_q == LIDX_W'(LABEL_LEN - 1))
          begin
            save_state_q <= CXBS_SAVE_IDLE;
            save_busy_q  <= 1'b0;
            nvm_wr_q     <= 1'b0;
          end
          else
          begin
            nvm_index_q <= nvm_index_q + LIDX_W'(1);
            nvm_char_q  <= label_q[nvm_index_q + LIDX_W'(1)];
          end
        default:
          save_state_q <= CXBS_SAVE_IDLE;
      endcase
    end
  end

  // ************************************
  // Assertions
  // ************************************
  AST_SPEED_WRITE: // R1
    assert property (@(posedge mclk) disable iff (reset)
      speed_wr && speed_legal(speed_wdata) |=> link_speed_select_q == $past(speed_wdata))
    else $error("link speed write not taken");
  AST_SPEED_LEGAL: // R1
    assert property (@(posedge mclk) disable iff (reset) speed_legal(link_speed_select_q))
    else $error("link speed holds an illegal code");
  AST_RESET_START: // R3
    assert property (@(posedge mclk) disable iff (reset)
      rst_state_q == CXBS_RST_IDLE && link_reset_wr && link_reset_wdata
      |=> link_reset_ctrl_q && link_reset_out_q)
    else $error("link reset not started");
  AST_RESET_CLEAR: // R21
    assert property (@(posedge mclk) disable iff (reset)
      link_reset_ctrl_q && link_reset_done |=> !link_reset_ctrl_q && !link_reset_out_q)
    else $error("link reset control did not clear");
  AST_STREAM_ALIGN: // R4
    assert property (@(posedge mclk) disable iff (reset)
      max_stream_pkt_bytes_q[1:0] == 2'h0 && max_ctrl_pkt_bytes_q[1:0] == 2'h0)
    else $error("packet size not a multiple of four");
  AST_ARRIVE_ID: // R9
    assert property (@(posedge mclk) disable iff (reset)
      link_id_rd |=> arriving_link_id_q == $past(link_id_rd_link))
    else $error("arriving link id wrong");
  AST_STORE_STICKY: // R22
    assert property (@(posedge mclk) disable iff (reset)
      self_check_word_q[STORE_BIT[7]] |=> self_check_word_q[STORE_BIT[7]])
    else $error("storage bit cleared");
  AST_ALIGN_HOLD: // R17
    assert property (@(posedge mclk) disable iff (reset)
      !align_tick |=> $stable(self_check_word_q[BIT_ALIGN]))
    else $error("alignment bit changed between refreshes");
  AST_SAVE_RUN: // R20
    assert property (@(posedge mclk) disable iff (reset)
      save_state_q == CXBS_SAVE_IDLE && save_label_cmd |=> nvm_wr_q [*8])
    else $error("label save stream broken");
endmodule
`default_nettype wire

// ===== hdl/cxbs_test_counters.sv
// Per-connection link test counters with a selected readout
`timescale 1ns/1ns
`default_nettype none
module cxbs_test_counters
  import cxbs_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  reset,
  cxbs_cnt_if.counter ci
);
  logic [CNT_W-1:0] tx_q  [NUM_LINKS];
  logic [CNT_W-1:0] rx_q  [NUM_LINKS];
  logic [CNT_W-1:0] err_q [NUM_LINKS];

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
    return v + CNT_W'(1);
  endfunction

  // ************************************
  // Counting
  // ************************************
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NUM_LINKS; i++)
    begin
      if (reset || ci.clear)
      begin
        tx_q[i]  <= '0;
        rx_q[i]  <= '0;
        err_q[i] <= '0;
      end
      else if (ci.enable && ci.evt_link == ID_W'(i))
      begin
        if (ci.tx_evt)
          tx_q[i] <= bump(tx_q[i]);
        if (ci.rx_evt)
          rx_q[i] <= bump(rx_q[i]);
        if (ci.err_evt)
          err_q[i] <= bump(err_q[i]);
      end
    end
  end

  // Selected connection readout
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ci.tx_total  <= '0;
      ci.rx_total  <= '0;
      ci.err_total <= '0;
    end
    else
    begin
      ci.tx_total  <= tx_q[ci.sel];   // R8
      ci.rx_total  <= rx_q[ci.sel];
      ci.err_total <= err_q[ci.sel];
    end
  end
endmodule
`default_nettype wire

// ===== shared/cxbs_cnt_if.sv
// Carrier between the register set and its test counters
`timescale 1ns/1ns
`default_nettype none
interface cxbs_cnt_if;
  import cxbs_pkg::*;
  logic              enable;
  logic              clear;
  logic [ID_W-1:0]   sel;
  logic [ID_W-1:0]   evt_link;
  logic              tx_evt;
  logic              rx_evt;
  logic              err_evt;
  logic [CNT_W-1:0]  tx_total;
  logic [CNT_W-1:0]  rx_total;
  logic [CNT_W-1:0]  err_total;
  modport regs (output enable, clear, sel, evt_link, tx_evt, rx_evt, err_evt,
                input tx_total, rx_total, err_total);
  modport counter (input enable, clear, sel, evt_link, tx_evt, rx_evt, err_evt,
                   output tx_total, rx_total, err_total);
endinterface
`default_nettype wire

// ===== shared/cxbs_pkg.sv
// Constants for the bootstrap and status register set
package cxbs_pkg;
  localparam int ID_W      = 2;
  localparam int NUM_LINKS = 4;
  localparam int CNT_W     = 32;
  localparam int TEMP_W    = 12;
  localparam int LABEL_LEN = 16;
  localparam int CHAR_W    = 8;
  localparam int LIDX_W    = 4;
  localparam int MAN_W     = 1;
  localparam int MAN_COUNT = 2;
  localparam int PTR_COUNT = 8;
  // Link speed encodings
  localparam logic [1:0] ONE_LINK_LOW_RATE  = 2'h1;
  localparam logic [1:0] ONE_LINK_MID_RATE  = 2'h2;
  localparam logic [1:0] ONE_LINK_HIGH_RATE = 2'h3;
  localparam logic [1:0] SPEED_RESET        = ONE_LINK_HIGH_RATE;
  localparam logic [7:0] ACTIVE_LINKS       = 8'h01;
  localparam logic [31:0] DEFAULT_LINK_SETTING = {22'h0, ACTIVE_LINKS, SPEED_RESET};
  localparam logic [31:0] MAX_CTRL_PKT_BYTES   = 32'h0000_0400;
  localparam logic [31:0] STREAM_PKT_RESET     = 32'h0;
  // Self-check bit positions
  localparam int BIT_BOOT  = 0;
  localparam int BIT_FLASH = 1;
  localparam int BIT_CFG   = 11;
  localparam int BIT_NAMES = 13;
  localparam int BIT_ALIGN = 14;
  localparam int STORE_BLOCKS = 8;
  localparam int STORE_BIT [STORE_BLOCKS] = '{2, 3, 4, 5, 6, 12, 15, 18};
  // Time base for the alignment refresh
  localparam longint ALIGN_PERIOD_NS = 1_000_000_000;
  localparam longint CLK_PERIOD_NS   = 4;
  localparam int ALIGN_CYCLES = int'(ALIGN_PERIOD_NS / CLK_PERIOD_NS);
  // Manifest table
  localparam logic [31:0] MAN_VERSION [MAN_COUNT] = '{32'h0001_0000, 32'h0001_0001};
  localparam logic [31:0] MAN_SCHEME  [MAN_COUNT] = '{32'h0001_0001, 32'h0001_0001};
  localparam logic [31:0] MAN_URL     [MAN_COUNT] = '{32'h0000_8000, 32'h0000_8100};
  // Feature address pointers: width, height, mode, start, stop, format, taps, stream
  localparam logic [31:0] FEAT_PTR [PTR_COUNT] = '{32'h0001_0000, 32'h0001_0004,
    32'h0001_0008, 32'h0001_000C, 32'h0001_0010, 32'h0001_0014, 32'h0001_0018, 32'h0001_001C};
endpackage

// ===== testbench/cxbs_link_model.sv
// Link-side model that answers a connection reset after a set delay
`timescale 1ns/1ns
`default_nettype none
module cxbs_link_model
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [3:0] done_delay,
  input  wire logic       link_reset_out_q,
  output logic            link_reset_done
);
  logic [3:0] wait_q;
  // Count while the reset request stands, then report done once
  always_ff @(posedge mclk)
  begin
    if (reset || !link_reset_out_q)
    begin
      wait_q          <= 4'h0;
      link_reset_done <= 1'b0;
    end
    else
    begin
      wait_q          <= wait_q + 4'h1;
      link_reset_done <= (wait_q == done_delay);
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the bootstrap register set
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import cxbs_pkg::*;
;
  logic mclk, reset, speed_wr, link_reset_wr, link_reset_wdata, link_reset_done, stream_size_wr;
  logic test_enable_wr, test_enable_wdata, counter_select_wr, test_tx_evt, test_rx_evt, test_err_evt;
  logic link_id_rd, master_host_wr, manifest_select_wr, boot_ok, flash_found, config_bad, names_bad;
  logic store_bad, align_fail, label_wr, save_label_cmd, link_reset_ctrl_q, link_reset_out_q;
  logic link_test_enable_q, nvm_wr_q, save_busy_q;
  logic [1:0]          speed_wdata, link_speed_select_q;
  logic [31:0]         stream_size_wdata, master_host_wdata, max_stream_pkt_bytes_q, max_ctrl_pkt_bytes_q;
  logic [31:0]         default_link_setting_q, master_host_link_id_q, manifest_count_q, manifest_version_q;
  logic [31:0]         manifest_scheme_q, manifest_url_q, self_check_word_q;
  logic [31:0]         feature_ptr_q [PTR_COUNT];
  logic [ID_W-1:0]     counter_select_wdata, test_evt_link, link_id_rd_link, test_counter_select_q;
  logic [ID_W-1:0]     arriving_link_id_q;
  logic [CNT_W-1:0]    test_error_total, test_tx_pkt_total, test_rx_pkt_total;
  logic [MAN_W-1:0]    manifest_select_wdata, manifest_select_q;
  logic [2:0]          store_block;
  logic [TEMP_W-1:0]   temp_sample, logic_temp_readout_q;
  logic [LIDX_W-1:0]   label_index, nvm_index_q;
  logic [CHAR_W-1:0]   label_wchar, label_rchar_q, nvm_char_q;
  logic [3:0]          done_delay;
  int                  num_errors, tests_run;

  cxbs_bootstrap_regs #(.ALIGN_TICK_CYCLES(16)) dut (.mclk, .reset, .speed_wr, .speed_wdata, .link_reset_wr,
    .link_reset_wdata, .link_reset_done, .stream_size_wr, .stream_size_wdata, .test_enable_wr,
    .test_enable_wdata, .counter_select_wr, .counter_select_wdata, .test_tx_evt, .test_rx_evt, .test_err_evt,
    .test_evt_link, .link_id_rd, .link_id_rd_link, .master_host_wr, .master_host_wdata, .manifest_select_wr,
    .manifest_select_wdata, .boot_ok, .flash_found, .config_bad, .names_bad, .store_bad, .store_block,
    .align_fail, .temp_sample, .label_wr, .label_index, .label_wchar, .save_label_cmd, .link_speed_select_q,
    .link_reset_ctrl_q, .link_reset_out_q, .max_stream_pkt_bytes_q, .max_ctrl_pkt_bytes_q,
    .default_link_setting_q, .link_test_enable_q, .test_counter_select_q, .test_error_total,
    .test_tx_pkt_total, .test_rx_pkt_total, .arriving_link_id_q, .master_host_link_id_q, .manifest_select_q,
    .manifest_count_q, .manifest_version_q, .manifest_scheme_q, .manifest_url_q, .feature_ptr_q,
    .self_check_word_q, .logic_temp_readout_q, .label_rchar_q, .nvm_wr_q, .nvm_index_q, .nvm_char_q,
    .save_busy_q);

  cxbs_link_model link (.mclk, .reset, .done_delay, .link_reset_out_q, .link_reset_done);

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One-cycle strobe, driven just after the edge
  task automatic pulse(ref logic s);
    @(posedge mclk);
    #1 s = 1'b1;
    @(posedge mclk);
    #1 s = 1'b0;
  endtask

  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk(32'(link_speed_select_q), 32'h3);
    chk(max_stream_pkt_bytes_q, 32'h0);
    chk(max_ctrl_pkt_bytes_q, 32'h400);
    chk(default_link_setting_q, {22'h0, 8'h01, 2'h3});
    chk(manifest_count_q, 32'h2);
    for (int i = 0; i < PTR_COUNT; i++)
      chk(feature_ptr_q[i], 32'h10000 + 32'(4 * i));
    chk(self_check_word_q, 32'h802);
    chk(32'(logic_temp_readout_q), 32'h5A3);
    $display("t_reset done");
  endtask

  task automatic t_speed;
    chk(32'(link_test_enable_q), 32'h0);
    for (int c = 1; c <= 3; c++)
    begin
      speed_wdata = 2'(c);
      pulse(speed_wr);
      chk(32'(link_speed_select_q), 32'(c));
    end
    speed_wdata = 2'h0;
    pulse(speed_wr);
    chk(32'(link_speed_select_q), 32'h3);
    stream_size_wdata = 32'h4000;
    pulse(stream_size_wr);
    chk(max_stream_pkt_bytes_q, 32'h4000);
    stream_size_wdata = 32'h4002;
    pulse(stream_size_wr);
    chk(max_stream_pkt_bytes_q, 32'h4000);
    $display("t_speed done");
  endtask

  task automatic t_link_reset(input logic [3:0] dly);
    int n;
    n = 0;
    done_delay = dly;
    link_reset_wdata = 1'b1;
    pulse(link_reset_wr);
    chk({30'h0, link_reset_ctrl_q, link_reset_out_q}, 32'h3);
    while (link_reset_ctrl_q === 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk(32'(link_reset_ctrl_q), 32'h0);
    chk(32'(n >= int'(dly)), 32'h1);
    $display("t_link_reset done");
  endtask

  task automatic t_test;
    test_enable_wdata = 1'b1;
    pulse(test_enable_wr);
    chk(32'(link_test_enable_q), 32'h1);
    tick(2);
    counter_select_wdata = 2'h1;
    pulse(counter_select_wr);
    chk(32'(test_counter_select_q), 32'h1);
    test_evt_link = 2'h1;
    pulse(test_tx_evt);
    pulse(test_tx_evt);
    pulse(test_err_evt);
    test_evt_link = 2'h2;
    pulse(test_rx_evt);
    tick(2);
    chk(test_tx_pkt_total, 32'h2);
    chk(test_error_total, 32'h1);
    chk(test_rx_pkt_total, 32'h0);
    counter_select_wdata = 2'h2;
    pulse(counter_select_wr);
    tick(1);
    chk(test_rx_pkt_total, 32'h1);
    chk(test_tx_pkt_total, 32'h0);
    test_enable_wdata = 1'b0;
    pulse(test_enable_wr);
    pulse(test_tx_evt);
    tick(2);
    chk(test_tx_pkt_total, 32'h0);
    $display("t_test done");
  endtask

  task automatic t_ids;
    link_id_rd_link = 2'h2;
    pulse(link_id_rd);
    chk(32'(arriving_link_id_q), 32'h2);
    master_host_wdata = 32'h0000_00A5;
    pulse(master_host_wr);
    chk(master_host_link_id_q, 32'h0000_00A5);
    manifest_select_wdata = 1'b1;
    pulse(manifest_select_wr);
    chk(32'(manifest_select_q), 32'h1);
    tick(2);
    chk(manifest_version_q, MAN_VERSION[1]);
    chk(manifest_scheme_q, MAN_SCHEME[1]);
    chk(manifest_url_q, MAN_URL[1]);
    $display("t_ids done");
  endtask

  task automatic t_check;
    store_block = 3'h7;
    pulse(store_bad);
    chk(self_check_word_q, 32'h40802);
    store_block = 3'h2;
    pulse(store_bad);
    chk(self_check_word_q, 32'h40812);
    align_fail = 1'b1;
    tick(20);
    chk(self_check_word_q, 32'h44812);
    align_fail = 1'b0;
    tick(20);
    chk(self_check_word_q, 32'h40812);
    $display("t_check done");
  endtask

  task automatic t_label;
    int n;
    n = 0;
    label_index = 4'hF;
    label_wchar = 8'h5A;
    pulse(label_wr);
    tick(1);
    chk(32'(label_rchar_q), 32'h5A);
    pulse(save_label_cmd);
    chk(32'(save_busy_q), 32'h1);
    repeat (20)
    begin
      if (nvm_wr_q === 1'b1)
      begin
        n++;
        if (nvm_index_q === 4'hF)
          chk(32'(nvm_char_q), 32'h5A);
      end
      tick(1);
    end
    chk(32'(n), 32'h10);
    $display("t_label done");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    {speed_wr, link_reset_wr, link_reset_wdata, stream_size_wr, test_enable_wr, test_enable_wdata} = '0;
    {counter_select_wr, test_tx_evt, test_rx_evt, test_err_evt, link_id_rd, master_host_wr} = '0;
    {manifest_select_wr, names_bad, store_bad, align_fail, label_wr, save_label_cmd, flash_found} = '0;
    {speed_wdata, stream_size_wdata, master_host_wdata, counter_select_wdata, test_evt_link} = '0;
    {link_id_rd_link, manifest_select_wdata, store_block, label_index, label_wchar} = '0;
    boot_ok = 1'b1;
    config_bad = 1'b1;
    temp_sample = 12'h5A3;
    done_delay = 4'h1;
    num_errors = 0;
    tests_run = 0;
    reset = 1'b1;
    repeat (8) @(posedge mclk);
    #1 reset = 1'b0;
    tick(3);
    t_reset;
    t_speed;
    t_link_reset(4'h1);
    t_link_reset(4'h9);
    t_test;
    t_ids;
    t_check;
    t_label;
    print_verdict;
  end

  initial
  begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
